// file: ioc_pkg.sv
package ioc_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PERIOD_US = 1000;
	localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_PERIOD_US;
	localparam int STEP_INTERVAL_MS = 100;
	localparam int N_INPUTS = 5;
	localparam int FREQ_W = 20;
	localparam int REG_W = 16;

	localparam logic [REG_W-1:0] CONFIRM_MAX = 16'h7530;
	localparam logic [REG_W-1:0] CONFIRM_RST = 16'h0005;
	localparam logic [REG_W-1:0] RATE_MIN = 16'h0001;
	localparam logic [REG_W-1:0] RATE_MAX = 16'h03e8;
	localparam logic [REG_W-1:0] RATE_RST = 16'h0001;
	localparam logic [REG_W-1:0] POL_RST = 16'h0000;
	localparam logic [REG_W-1:0] DWELL_RST = 16'h03e8;
	localparam logic [2:0] AUTO_STEPS_RST = 3'h7;
	localparam int SAVE_BIT = 7;

	localparam logic [11:0] IDX_RAMP_MODE = 12'h209;
	localparam logic [11:0] IDX_STEP_RATE = 12'h20a;
	localparam logic [11:0] IDX_CONFIRM = 12'h20b;
	localparam logic [11:0] IDX_POLARITY = 12'h20c;
	localparam logic [11:0] IDX_FUNC_BASE = 12'h300;
	localparam logic [11:0] IDX_SAVE_CTRL = 12'h310;
	localparam logic [11:0] IDX_ACCEL = 12'h311;
	localparam logic [11:0] IDX_DECEL = 12'h312;
	localparam logic [11:0] IDX_DWELL = 12'h313;
	localparam logic [11:0] IDX_AUTO_LAST = 12'h314;
	localparam logic [11:0] IDX_IN_STATUS = 12'h320;
	localparam logic [11:0] IDX_FREQ_CMD = 12'h321;
	localparam logic [11:0] IDX_DRV_STATUS = 12'h322;

	localparam logic [7:0] FN_UP = 8'h13;
	localparam logic [7:0] FN_DOWN = 8'h14;
	localparam logic [7:0] FN_AUTO_RUN = 8'h5e;
	localparam logic [7:0] FN_AUTO_PAUSE = 8'h5f;
	localparam logic [7:0] FN_HAND_AUTO = 8'h61;
	localparam logic [7:0] FN_FWD_LIMIT = 8'h62;
	localparam logic [7:0] FN_REV_LIMIT = 8'h63;

	typedef enum logic [2:0] {
		RAMP_ACCEL = 3'b000,
		RAMP_CONST = 3'b001,
		RAMP_PULSE = 3'b010,
		RAMP_CURVE = 3'b011,
		RAMP_TIMED = 3'b100
	} ioc_ramp_e;

	typedef enum logic [1:0] {
		AUTO_IDLE = 2'b00,
		AUTO_RUN = 2'b01,
		AUTO_PAUSE = 2'b10
	} ioc_auto_e;
endpackage

// file: ioc_confirm_filter.sv
`timescale 1ns/1ps
module ioc_confirm_filter #(
	parameter int N = 5,
	parameter int W = 16
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic tick_ms_in,
	input wire logic [W-1:0] confirm_ms_in,
	input wire logic [N-1:0] raw_in,
	output logic [N-1:0] stable_out
);
	if (N < 1 || W < 2) begin : g_chk
		$error("ioc_confirm_filter: bad width");
	end

	for (genvar i = 0; i < N; i++) begin : g_ch
		logic last_q;
		logic stable_q;
		logic [W-1:0] cnt_q;
		wire logic differs = (last_q != stable_q);
		wire logic done = (cnt_q >= confirm_ms_in);

		assign stable_out[i] = stable_q;

		always_ff @(posedge mclk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				last_q <= 1'b0;
				stable_q <= 1'b0;
				cnt_q <= '0;
			end else begin
				last_q <= raw_in[i];
				if (raw_in[i] != last_q || !differs) begin
					cnt_q <= '0;
				end else if (done) begin
					stable_q <= last_q;
					cnt_q <= '0;
				end else if (tick_ms_in) begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule

// file: ioc_updown_stepper.sv
`timescale 1ns/1ps
module ioc_updown_stepper
	import ioc_pkg::*;
#(
	parameter int FW = 20,
	parameter logic [FW-1:0] FREQ_MAX = 20'h927c0
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic tick_ms_in,
	input wire logic up_in,
	input wire logic down_in,
	input wire logic running_in,
	input wire logic clear_at_stop_in,
	input wire logic [2:0] mode_in,
	input wire logic [15:0] rate_in,
	input wire logic [15:0] accel_in,
	input wire logic [15:0] decel_in,
	output logic [FW-1:0] freq_out
);
	if (FW < 17) begin : g_chk
		$error("ioc_updown_stepper: frequency too narrow");
	end

	logic [FW-1:0] freq_q;
	logic [FW-1:0] curve_q;
	logic [6:0] iv_q;
	logic up_q;
	logic down_q;

	function automatic logic [FW-1:0] step_to(input logic [FW-1:0] f,
			input logic [FW-1:0] d, input logic up);
		logic [FW:0] s;
		s = '0;
		if (up) begin
			s = {1'b0, f} + {1'b0, d};
			step_to = (s > {1'b0, FREQ_MAX}) ? FREQ_MAX : s[FW-1:0];
		end else begin
			step_to = (f > d) ? f - d : '0;
		end
	endfunction

	wire logic one_dir = up_in ^ down_in;
	wire logic held = up_in | down_in;
	wire logic iv_end = tick_ms_in &&
		(iv_q == 7'(STEP_INTERVAL_MS - 1));
	wire logic pulse = (up_in & ~up_q) ^ (down_in & ~down_q);
	wire logic allow = running_in | ~clear_at_stop_in;
	wire logic [FW-1:0] rate_f = FW'(rate_in);
	wire logic [FW-1:0] ramp_f = FW'(up_in ? accel_in : decel_in);
	wire logic [FW-1:0] grow = curve_q + (curve_q >> 3) + 1'b1;

	logic go;
	logic [FW-1:0] delta;
	always_comb begin
		go = 1'b0;
		delta = rate_f;
		case (mode_in)
			RAMP_ACCEL: begin
				go = tick_ms_in & one_dir;
				delta = ramp_f;
			end
			RAMP_CONST: go = tick_ms_in & one_dir;
			RAMP_PULSE: go = pulse & one_dir;
			RAMP_CURVE: begin
				go = tick_ms_in & one_dir;
				delta = curve_q;
			end
			RAMP_TIMED: go = iv_end & one_dir;
			default: go = 1'b0;
		endcase
	end

	assign freq_out = freq_q;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			freq_q <= '0;
			curve_q <= '0;
			iv_q <= '0;
			up_q <= 1'b0;
			down_q <= 1'b0;
		end else begin
			up_q <= up_in;
			down_q <= down_in;
			if (!held) begin
				iv_q <= '0;
			end else if (iv_end) begin
				iv_q <= '0;
			end else if (tick_ms_in) begin
				iv_q <= iv_q + 1'b1;
			end
			if (!held) begin
				curve_q <= rate_f;
			end else if (iv_end) begin
				curve_q <= (grow > FREQ_MAX) ? FREQ_MAX : grow;
			end
			if (clear_at_stop_in && !running_in) begin
				freq_q <= '0;
			end else if (allow && go) begin
				freq_q <= step_to(freq_q, delta, up_in);
			end
		end
	end
endmodule

// file: ioc_input_top.sv
`timescale 1ns/1ps
module ioc_input_top
	import ioc_pkg::*;
#(
	parameter int MS_CYC = ioc_pkg::MS_CYCLES,
	parameter int N = ioc_pkg::N_INPUTS
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [13:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [N-1:0] di_in,
	input wire logic run_fwd_in,
	input wire logic run_rev_in,
	output logic [N-1:0] di_active_out,
	output logic [ioc_pkg::FREQ_W-1:0] freq_cmd_out,
	output logic auto_run_out,
	output logic auto_paused_out,
	output logic [2:0] auto_step_out,
	output logic hand_mode_out,
	output logic stop_fwd_out,
	output logic stop_rev_out
);
	if (MS_CYC < 2 || N != N_INPUTS) begin : g_chk
		$error("ioc_input_top: unsupported parameter");
	end

	localparam int TW = $clog2(MS_CYC);

	// ------------------------------------------------------------
	// Millisecond time base
	// ------------------------------------------------------------
	logic [TW-1:0] div_q;
	logic tick_q;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == TW'(MS_CYC - 1));
			div_q <= (div_q == TW'(MS_CYC - 1)) ? '0 : div_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [2:0] mode_q;
	logic [15:0] rate_q;
	logic [15:0] confirm_q;
	logic [15:0] pol_q;
	logic [15:0] save_q;
	logic [15:0] accel_q;
	logic [15:0] decel_q;
	logic [15:0] dwell_q;
	logic [2:0] last_step_q;
	logic [7:0] func_q [N];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	wire logic [11:0] idx = paddr_in[13:2];
	wire logic setup = psel_in & ~penable_in;
	wire logic wr = psel_in & penable_in & pready_q & pwrite_in & ~pslverr_q;
	wire logic [15:0] wv = pwdata_in[15:0];
	wire logic func_hit = (idx >= IDX_FUNC_BASE) &&
		(idx < IDX_FUNC_BASE + 12'(N));
	wire logic [2:0] func_sel = 3'(idx - IDX_FUNC_BASE);

	function automatic logic [15:0] clamp(input logic [15:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_q <= RAMP_ACCEL;
			rate_q <= RATE_RST;
			confirm_q <= CONFIRM_RST;
			pol_q <= POL_RST;
			save_q <= '0;
			accel_q <= RATE_RST;
			decel_q <= RATE_RST;
			dwell_q <= DWELL_RST;
			last_step_q <= AUTO_STEPS_RST;
		end else if (wr) begin
			case (idx)
				IDX_RAMP_MODE: mode_q <= (wv > 16'(RAMP_TIMED)) ?
					RAMP_TIMED : wv[2:0];
				IDX_STEP_RATE: rate_q <= clamp(wv, RATE_MIN, RATE_MAX);
				IDX_CONFIRM: confirm_q <= clamp(wv, '0, CONFIRM_MAX);
				IDX_POLARITY: pol_q <= wv;
				IDX_SAVE_CTRL: save_q <= wv;
				IDX_ACCEL: accel_q <= clamp(wv, RATE_MIN, RATE_MAX);
				IDX_DECEL: decel_q <= clamp(wv, RATE_MIN, RATE_MAX);
				IDX_DWELL: dwell_q <= clamp(wv, RATE_MIN, 16'hffff);
				IDX_AUTO_LAST: last_step_q <= wv[2:0];
				default: last_step_q <= last_step_q;
			endcase
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_func
		always_ff @(posedge mclk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				func_q[i] <= '0;
			end else if (wr && func_hit && func_sel == 3'(i)) begin
				func_q[i] <= wv[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------
	logic [N-1:0] stable;
	logic [N-1:0] active_q;

	ioc_confirm_filter #(
		.N(N),
		.W(16)
	) u_filter (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.tick_ms_in(tick_q),
		.confirm_ms_in(confirm_q),
		.raw_in(di_in),
		.stable_out(stable)
	);

	wire logic [N-1:0] active = stable ^ pol_q[N-1:0];

	function automatic logic fn_on(input logic [7:0] code,
			input logic [N-1:0] act, input logic [8*N-1:0] fmap);
		fn_on = 1'b0;
		for (int k = 0; k < N; k++) begin
			if (act[k] && fmap[8*k +: 8] == code) begin
				fn_on = 1'b1;
			end
		end
	endfunction

	logic [8*N-1:0] fmap;
	always_comb begin
		fmap = '0;
		for (int k = 0; k < N; k++) begin
			fmap[8*k +: 8] = func_q[k];
		end
	end

	wire logic fn_up = fn_on(FN_UP, active, fmap);
	wire logic fn_down = fn_on(FN_DOWN, active, fmap);
	wire logic fn_auto = fn_on(FN_AUTO_RUN, active, fmap);
	wire logic fn_pause = fn_on(FN_AUTO_PAUSE, active, fmap);
	wire logic fn_hand = fn_on(FN_HAND_AUTO, active, fmap);
	wire logic fn_fwd_lim = fn_on(FN_FWD_LIMIT, active, fmap);
	wire logic fn_rev_lim = fn_on(FN_REV_LIMIT, active, fmap);
	wire logic running = run_fwd_in | run_rev_in;

	ioc_updown_stepper #(
		.FW(FREQ_W)
	) u_stepper (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.tick_ms_in(tick_q),
		.up_in(fn_up),
		.down_in(fn_down),
		.running_in(running),
		.clear_at_stop_in(save_q[SAVE_BIT]),
		.mode_in(mode_q),
		.rate_in(rate_q),
		.accel_in(accel_q),
		.decel_in(decel_q),
		.freq_out(freq_cmd_out)
	);

	// ------------------------------------------------------------
	// Auto-run sequencer and limit stops
	// ------------------------------------------------------------
	ioc_auto_e auto_q;
	logic [15:0] dwell_cnt_q;
	logic [2:0] step_q;
	logic hand_q;
	logic hand_prev_q;
	logic stop_fwd_q;
	logic stop_rev_q;
	logic auto_on_q;
	logic auto_hold_q;

	wire logic dwell_done = tick_q && (dwell_cnt_q + 1'b1 >= dwell_q);
	wire logic [2:0] step_next = (step_q >= last_step_q) ? '0 :
		step_q + 1'b1;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			auto_q <= AUTO_IDLE;
			dwell_cnt_q <= '0;
			step_q <= '0;
		end else begin
			case (auto_q)
				AUTO_IDLE: begin
					dwell_cnt_q <= '0;
					step_q <= '0;
					if (fn_auto) begin
						auto_q <= AUTO_RUN;
					end
				end
				AUTO_RUN: begin
					if (!fn_auto) begin
						auto_q <= AUTO_IDLE;
					end else if (fn_pause) begin
						auto_q <= AUTO_PAUSE;
					end else if (dwell_done) begin
						dwell_cnt_q <= '0;
						step_q <= step_next;
					end else if (tick_q) begin
						dwell_cnt_q <= dwell_cnt_q + 1'b1;
					end
				end
				AUTO_PAUSE: begin
					if (!fn_auto) begin
						auto_q <= AUTO_IDLE;
					end else if (!fn_pause) begin
						auto_q <= AUTO_RUN;
					end
				end
				default: auto_q <= AUTO_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hand_q <= 1'b0;
			hand_prev_q <= 1'b0;
			stop_fwd_q <= 1'b0;
			stop_rev_q <= 1'b0;
			active_q <= '0;
			auto_on_q <= 1'b0;
			auto_hold_q <= 1'b0;
		end else begin
			auto_on_q <= (auto_q != AUTO_IDLE);
			auto_hold_q <= (auto_q == AUTO_PAUSE);
			hand_prev_q <= fn_hand;
			if (fn_hand && !hand_prev_q) begin
				hand_q <= ~hand_q;
			end
			stop_fwd_q <= fn_fwd_lim & run_fwd_in;
			stop_rev_q <= fn_rev_lim & run_rev_in;
			active_q <= active;
		end
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	logic [31:0] rd;
	logic rd_ok;
	always_comb begin
		rd = '0;
		rd_ok = 1'b1;
		case (idx)
			IDX_RAMP_MODE: rd = 32'(mode_q);
			IDX_STEP_RATE: rd = 32'(rate_q);
			IDX_CONFIRM: rd = 32'(confirm_q);
			IDX_POLARITY: rd = 32'(pol_q);
			IDX_SAVE_CTRL: rd = 32'(save_q);
			IDX_ACCEL: rd = 32'(accel_q);
			IDX_DECEL: rd = 32'(decel_q);
			IDX_DWELL: rd = 32'(dwell_q);
			IDX_AUTO_LAST: rd = 32'(last_step_q);
			IDX_IN_STATUS: rd = {16'h0000, 3'h0, stable, 3'h0, active};
			IDX_FREQ_CMD: rd = 32'(freq_cmd_out);
			IDX_DRV_STATUS: rd = {24'h00_0000, step_q, auto_q,
				hand_q, stop_fwd_q, stop_rev_q};
			default: begin
				rd_ok = func_hit;
				rd = func_hit ? 32'(func_q[func_sel]) : '0;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~rd_ok;
			if (setup) begin
				prdata_q <= pwrite_in ? '0 : rd;
			end
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign di_active_out = active_q;
	assign auto_run_out = auto_on_q;
	assign auto_paused_out = auto_hold_q;
	assign auto_step_out = step_q;
	assign hand_mode_out = hand_q;
	assign stop_fwd_out = stop_fwd_q;
	assign stop_rev_out = stop_rev_q;
endmodule

// file: ioc_input_props.sv
`timescale 1ns/1ps
module ioc_input_props
	import ioc_pkg::*;
#(
	parameter int MS_CYC = 10,
	parameter int N = 5
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [13:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [N-1:0] di_in,
	input wire logic run_fwd_in,
	input wire logic run_rev_in,
	input wire logic [N-1:0] di_active_out,
	input wire logic [ioc_pkg::FREQ_W-1:0] freq_cmd_out,
	input wire logic auto_run_out,
	input wire logic auto_paused_out,
	input wire logic [2:0] auto_step_out,
	input wire logic hand_mode_out,
	input wire logic stop_fwd_out,
	input wire logic stop_rev_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	a_pready_next: assert property (psel_in && !penable_in |=> pready_out)
		else $error("No ready after setup cycle.");
	a_pready_access: assert property (pready_out |-> psel_in && penable_in)
		else $error("Ready outside an access cycle.");
	a_pready_pulse: assert property (pready_out |=> !pready_out)
		else $error("Ready held longer than one cycle.");
	a_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("Error flag without ready.");
	a_upper_zero: assert property (pready_out && !pwrite_in
		|-> prdata_out[31:16] == 16'h0000)
		else $error("Upper read data bits not zero.");
	a_filter_settled: assert property (
		$changed(di_active_out) && $stable(di_active_out ^ di_in)
		|-> $past(di_in, 1) == $past(di_in, 2))
		else $error("Input accepted before it settled.");
	a_freq_ceiling: assert property (freq_cmd_out <= 20'h9_27c0)
		else $error("Frequency command above ceiling.");
	a_pause_in_auto: assert property (auto_paused_out |-> auto_run_out)
		else $error("Pause shown while auto-run idle.");
	a_stop_fwd_run: assert property (stop_fwd_out |-> $past(run_fwd_in))
		else $error("Forward stop without forward run.");
	a_stop_rev_run: assert property (stop_rev_out |-> $past(run_rev_in))
		else $error("Reverse stop without reverse run.");

	c_slverr: cover property (pready_out && pslverr_out);
	c_stop_fwd: cover property (stop_fwd_out);
	c_paused: cover property (auto_paused_out);
	c_hand: cover property ($changed(hand_mode_out));
endmodule
bind ioc_input_top ioc_input_props #(.MS_CYC(MS_CYC), .N(N)) u_props (
	.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .di_in(di_in),
	.run_fwd_in(run_fwd_in), .run_rev_in(run_rev_in),
	.di_active_out(di_active_out), .freq_cmd_out(freq_cmd_out),
	.auto_run_out(auto_run_out), .auto_paused_out(auto_paused_out),
	.auto_step_out(auto_step_out), .hand_mode_out(hand_mode_out),
	.stop_fwd_out(stop_fwd_out), .stop_rev_out(stop_rev_out)
);

// file: ioc_contact_model.sv
`timescale 1ns/1ps
module ioc_contact_model (
	input wire logic mclk_in,
	input wire logic [4:0] press_in,
	output logic [4:0] di_out
);
	// Contacts chatter for four cycles after every change of position.
	logic [4:0] pos_q = 5'h00;
	logic [4:0] chg_q = 5'h00;
	int bounce = 0;
	initial di_out = 5'h00;
	always @(posedge mclk_in) begin
		if (press_in != pos_q) begin
			chg_q = press_in ^ pos_q;
			pos_q = press_in;
			bounce = 4;
		end
		if (bounce != 0) begin
			di_out <= di_out ^ chg_q;
			bounce--;
		end else begin
			di_out <= pos_q;
		end
	end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	import ioc_pkg::*;
	localparam int MS = 10;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic run_fwd = 1'b0, run_rev = 1'b0;
	logic [4:0] press = 5'h00;
	logic [4:0] di, di_act;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, auto_run, auto_pause, hand, stop_f, stop_r;
	logic [2:0] auto_step;
	logic [19:0] freq;
	int err_total = 0;
	int compares = 0;

	always #10 mclk_in = ~mclk_in;

	ioc_input_top #(.MS_CYC(MS), .N(5)) u_dut (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .di_in(di), .run_fwd_in(run_fwd),
		.run_rev_in(run_rev), .di_active_out(di_act), .freq_cmd_out(freq),
		.auto_run_out(auto_run), .auto_paused_out(auto_pause),
		.auto_step_out(auto_step), .hand_mode_out(hand),
		.stop_fwd_out(stop_f), .stop_rev_out(stop_r)
	);
	ioc_contact_model u_sw (.mclk_in(mclk_in), .press_in(press), .di_out(di));

	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] idx, input logic [15:0] wd);
		int n;
		@(posedge mclk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge mclk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			tally_and_finish();
		end
	endtask

	task ms(input int n);
		repeat (n * MS) @(posedge mclk_in);
	endtask

	task push(input logic [4:0] m, input logic v);
		@(posedge mclk_in);
		press <= v ? (press | m) : (press & ~m);
	endtask

	task pulse(input logic [4:0] m);
		push(m, 1'b1);
		ms(5);
		push(m, 1'b0);
		ms(5);
	endtask

	task t_regs;
		apb(0, IDX_RAMP_MODE, 16'h0000);
		chk(rd, 32'h0000_0000);
		apb(0, IDX_STEP_RATE, 16'h0000);
		chk(rd, 32'h0000_0001);
		apb(0, IDX_CONFIRM, 16'h0000);
		chk(rd, 32'h0000_0005);
		apb(0, IDX_POLARITY, 16'h0000);
		chk(rd, 32'h0000_0000);
		apb(0, 12'h100, 16'h0000);
		chk({31'h0, er}, 32'h0000_0001);
		apb(1, IDX_CONFIRM, 16'h0002);
		apb(0, IDX_CONFIRM, 16'h0000);
		chk(rd, 32'h0000_0002);
	endtask

	task t_filter;
		push(5'h01, 1'b1);
		repeat (10) @(posedge mclk_in);
		chk({27'h0, di_act}, 32'h0000_0000);
		repeat (70) @(posedge mclk_in);
		chk({27'h0, di_act}, 32'h0000_0001);
		push(5'h01, 1'b0);
		ms(9);
		apb(1, IDX_POLARITY, 16'h0004);
		repeat (5) @(posedge mclk_in);
		chk({27'h0, di_act}, 32'h0000_0004);
		apb(1, IDX_POLARITY, 16'h0000);
	endtask

	task automatic t_modes;
		int hold[5] = '{30, 30, 5, 150, 250};
		int lo[5] = '{112, 84, 3, 470, 6};
		int hi[5] = '{128, 96, 3, 1200, 6};
		logic [19:0] f0;
		apb(1, IDX_FUNC_BASE, {8'h00, FN_UP});
		apb(1, IDX_FUNC_BASE + 12'h001, {8'h00, FN_DOWN});
		apb(1, IDX_STEP_RATE, 16'h0003);
		apb(1, IDX_ACCEL, 16'h0004);
		for (int m = 0; m < 5; m++) begin
			apb(1, IDX_RAMP_MODE, m[15:0]);
			f0 = freq;
			push(5'h01, 1'b1);
			ms(hold[m]);
			push(5'h01, 1'b0);
			ms(5);
			chk({31'h0, int'(freq - f0) inside {[lo[m]:hi[m]]}}, 32'h1);
		end
		apb(1, IDX_RAMP_MODE, 16'h0002);
		f0 = freq;
		pulse(5'h02);
		chk({12'h0, freq}, {12'h0, f0 - 20'h0_0003});
		apb(1, IDX_RAMP_MODE, 16'h0001);
		f0 = freq;
		push(5'h04, 1'b1);
		ms(20);
		push(5'h04, 1'b0);
		ms(5);
		chk({12'h0, freq}, {12'h0, f0});
	endtask

	task t_save;
		apb(1, IDX_RAMP_MODE, 16'h0002);
		apb(1, IDX_SAVE_CTRL, 16'h0080);
		ms(1);
		chk({12'h0, freq}, 32'h0000_0000);
		pulse(5'h01);
		chk({12'h0, freq}, 32'h0000_0000);
		run_fwd <= 1'b1;
		pulse(5'h01);
		chk({12'h0, freq}, 32'h0000_0003);
		run_fwd <= 1'b0;
		ms(1);
		chk({12'h0, freq}, 32'h0000_0000);
		apb(1, IDX_SAVE_CTRL, 16'h0000);
	endtask

	task t_limits;
		apb(1, IDX_FUNC_BASE + 12'h002, {8'h00, FN_FWD_LIMIT});
		apb(1, IDX_FUNC_BASE + 12'h003, {8'h00, FN_REV_LIMIT});
		run_rev <= 1'b1;
		push(5'h04, 1'b1);
		ms(4);
		chk({30'h0, stop_f, stop_r}, 32'h0000_0000);
		run_fwd <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk({30'h0, stop_f, stop_r}, 32'h0000_0002);
		push(5'h08, 1'b1);
		ms(4);
		chk({30'h0, stop_f, stop_r}, 32'h0000_0003);
		run_fwd <= 1'b0;
		run_rev <= 1'b0;
		push(5'h0c, 1'b0);
		ms(4);
		chk({30'h0, stop_f, stop_r}, 32'h0000_0000);
	endtask

	task t_auto;
		logic h;
		logic [2:0] s;
		apb(1, IDX_DWELL, 16'h0005);
		apb(1, IDX_FUNC_BASE + 12'h002, {8'h00, FN_HAND_AUTO});
		apb(1, IDX_FUNC_BASE + 12'h003, {8'h00, FN_AUTO_PAUSE});
		apb(1, IDX_FUNC_BASE + 12'h004, {8'h00, FN_AUTO_RUN});
		h = hand;
		pulse(5'h04);
		chk({31'h0, hand}, {31'h0, ~h});
		push(5'h10, 1'b1);
		ms(4);
		chk({31'h0, auto_run}, 32'h1);
		s = auto_step;
		ms(12);
		chk({31'h0, auto_step !== s}, 32'h1);
		push(5'h08, 1'b1);
		ms(4);
		s = auto_step;
		chk({31'h0, auto_pause}, 32'h1);
		ms(20);
		chk({29'h0, auto_step}, {29'h0, s});
		push(5'h08, 1'b0);
		ms(12);
		chk({31'h0, auto_step !== s}, 32'h1);
		push(5'h10, 1'b0);
	endtask

	initial begin
		repeat (20) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_regs();
		t_filter();
		t_modes();
		t_save();
		t_limits();
		t_auto();
		tally_and_finish();
	end
endmodule
